/* logic/pipelined_burst_sram.sv */
/*
  access pipeline, burst counter, sleep control and storage array of the sram.
  assumes the controller drives the synchronous pins on this clock; the output
  enable, sleep and strap pins are asynchronous and are synchronised here.
*/
module pipelined_burst_sram
  import sram_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES  = LANES_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clock_qualifier_n,
  input  wire logic                    chip_select_first_n,
  input  wire logic                    chip_select_second,
  input  wire logic                    chip_select_third_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    advance_or_load,
  input  wire logic [LANES-1:0]        byte_lane_select_n,
  input  wire logic [ADDR_W-1:0]       address,
  input  wire logic                    output_enable_n,
  input  wire logic                    sleep_request,
  input  wire logic                    burst_order,
  input  wire logic [LANES*LANE_W-1:0] data_in,
  output var  logic [LANES*LANE_W-1:0] data_out,
  output var  logic                    data_oe,
  input  wire logic [LANES-1:0]        parity_in,
  output var  logic [LANES-1:0]        parity_out,
  output var  logic                    parity_oe,
  output var  logic                    accept_ready
);
  localparam int DATA_W  = LANES * LANE_W;
  localparam int WORD_W  = DATA_W + LANES;        // {parity, data}
  localparam int ENTRY_W = ADDR_W + LANES + WORD_W; // {addr, lanes, word}

  // storage array, one word of data plus parity per address
  logic [WORD_W-1:0]  mem [2**ADDR_W];

  // synchronisers for the asynchronous pins
  logic               sleep_meta_reg;
  logic               sleep_active_reg;
  logic               oe_meta_reg;
  logic               oe_n_sync_reg;
  logic               order_meta_reg;
  logic               order_reg;

  // burst state
  logic [ADDR_W-1:0]  base_reg;
  logic [BURST_W-1:0] burst_count_reg;
  op_t                burst_dir_reg;

  // stage one: operation issued at the last qualified edge
  op_t                op_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [LANES-1:0]   lanes_reg;

  // stage two: write beat awaiting its data, read word being driven
  logic               wr_pend_reg;
  logic [ADDR_W-1:0]  wr_addr_reg;
  logic [LANES-1:0]   wr_lanes_reg;
  logic               drive_active_reg;
  logic [WORD_W-1:0]  rd_word_reg;
  logic               drive_oe_reg;

  wbuf_if #(.WORD_W(ENTRY_W)) wb ();

  write_buffer #(
    .WORD_W (ENTRY_W)
  ) u_write_buffer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .port_b  (wb)
  );

  // merge one buffered beat over a word read from the array
  function automatic logic [WORD_W-1:0] overlay(input logic [WORD_W-1:0] w,
                                                input logic              v,
                                                input logic [ENTRY_W-1:0] e,
                                                input logic [ADDR_W-1:0]  a);
    logic [WORD_W-1:0] r;
    r = w;
    if (v && e[ENTRY_W-1 -: ADDR_W] == a) begin
      for (int l = 0; l < LANES; l++) begin
        if (e[WORD_W+l]) begin
          r[l*LANE_W +: LANE_W] = e[l*LANE_W +: LANE_W];
          r[DATA_W+l]           = e[DATA_W+l];
        end
      end
    end
    return r;
  endfunction

  // a stalled edge or a full buffer freezes the pipeline; sleep idles it
  wire                qual        = ~clock_qualifier_n & wb.in_ready & ~sleep_active_reg;
  wire                selected    = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;
  wire                load        = ~advance_or_load & selected;
  wire [BURST_W-1:0]  count_step  = burst_count_reg + BEAT_STEP;
  wire [BURST_W-1:0]  base_low    = base_reg[BURST_W-1:0];
  wire [BURST_W-1:0]  burst_low   = order_reg ? (base_low ^ count_step)
                                              : (base_low + count_step);
  wire [ADDR_W-1:0]   burst_addr  = {base_reg[ADDR_W-1:BURST_W], burst_low};
  wire                load_dir_rd = write_strobe_n;

  // advance ignores selects and strobe; a deselect idles the pipe
  wire op_t           issue_op    = load ? (load_dir_rd ? op_read : op_write)
                                         : (advance_or_load ? burst_dir_reg : op_idle);
  wire [ADDR_W-1:0]   issue_addr  = load ? address : burst_addr;

  // array port: a read in progress blocks the buffer drain for that cycle
  wire                rd_now      = qual & (op_reg == op_read);
  wire                drain       = wb.out_valid & ~rd_now;
  wire [ENTRY_W-1:0]  drain_entry = wb.out_word;
  wire [ADDR_W-1:0]   drain_addr  = drain_entry[ENTRY_W-1 -: ADDR_W];
  wire [LANES-1:0]    drain_lanes = drain_entry[WORD_W +: LANES];
  wire [WORD_W-1:0]   array_word  = mem[addr_reg];
  wire [WORD_W-1:0]   fwd_head    = overlay(array_word, wb.out_valid, wb.out_word, addr_reg);
  wire [WORD_W-1:0]   fwd_word    = overlay(fwd_head, wb.tail_valid, wb.tail_word, addr_reg);

  // write data is captured straight from the pins into the buffer
  assign wb.in_valid  = qual & wr_pend_reg;
  assign wb.in_word   = {wr_addr_reg, wr_lanes_reg, parity_in, data_in};
  assign wb.out_ready = ~rd_now;

  // driver state for the edge being taken now
  wire                drive_next  = sleep_active_reg ? 1'h0
                                  : (qual ? (op_reg == op_read) : drive_active_reg);

  assign data_out     = rd_word_reg[DATA_W-1:0];
  assign parity_out   = rd_word_reg[WORD_W-1:DATA_W];
  assign data_oe      = drive_oe_reg;
  assign parity_oe    = drive_oe_reg;
  assign accept_ready = wb.in_ready;

  // two flops on every asynchronous pin; sleep entry and exit take two clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_meta_reg   <= SYNC_RESET;
      sleep_active_reg <= SYNC_RESET;
      oe_meta_reg      <= OE_N_RESET;
      oe_n_sync_reg    <= OE_N_RESET;
      order_meta_reg   <= STRAP_RESET;
      order_reg        <= STRAP_RESET;
    end else begin
      sleep_meta_reg   <= sleep_request;
      sleep_active_reg <= sleep_meta_reg;
      oe_meta_reg      <= output_enable_n;
      oe_n_sync_reg    <= oe_meta_reg;
      order_meta_reg   <= burst_order;
      order_reg        <= order_meta_reg;
    end
  end

  // burst counter: load resets the beat, advance steps it, deselect ends the burst
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_reg        <= '0;
      burst_count_reg <= BEAT_FIRST;
      burst_dir_reg   <= op_idle;
    end else if (sleep_active_reg) begin
      burst_dir_reg   <= op_idle;
    end else if (qual) begin
      if (load) begin
        base_reg        <= address;
        burst_count_reg <= BEAT_FIRST;
        burst_dir_reg   <= load_dir_rd ? op_read : op_write;
      end else if (advance_or_load) begin
        burst_count_reg <= count_step;
      end else begin
        burst_dir_reg   <= op_idle;
      end
    end
  end

  // stage one holds the tag, address and lane mask of this beat
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg    <= op_idle;
      addr_reg  <= '0;
      lanes_reg <= '0;
    end else if (sleep_active_reg) begin
      op_reg    <= op_idle;
    end else if (qual) begin
      op_reg    <= issue_op;
      addr_reg  <= issue_addr;
      lanes_reg <= ~byte_lane_select_n;
    end
  end

  // stage two: launch read data, or wait one edge for write data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg  <= 1'h0;
      wr_addr_reg  <= '0;
      wr_lanes_reg <= '0;
      rd_word_reg  <= '0;
    end else if (sleep_active_reg) begin
      wr_pend_reg  <= 1'h0;
    end else if (qual) begin
      wr_pend_reg  <= (op_reg == op_write);
      wr_addr_reg  <= addr_reg;
      wr_lanes_reg <= lanes_reg;
      if (op_reg == op_read) begin
        rd_word_reg <= fwd_word;
      end
    end
  end

  // drivers follow the pipeline, masked by the output enable and by sleep
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_active_reg <= 1'h0;
      drive_oe_reg     <= 1'h0;
    end else begin
      drive_active_reg <= drive_next;
      drive_oe_reg     <= drive_next & ~oe_n_sync_reg & ~sleep_active_reg;
    end
  end

  // array update from the buffer head; unselected lanes are left alone
  always_ff @(posedge clk) begin
    if (drain) begin
      for (int l = 0; l < LANES; l++) begin
        if (drain_lanes[l]) begin
          mem[drain_addr][l*LANE_W +: LANE_W] <= drain_entry[l*LANE_W +: LANE_W];
          mem[drain_addr][DATA_W+l]           <= drain_entry[DATA_W+l];
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  stall_hold_a: assert property (
    clock_qualifier_n && !sleep_active_reg |=> $stable(op_reg) && $stable(addr_reg) && $stable(burst_count_reg))
    else $error("state changed on an ignored edge");

  read_launch_a: assert property (
    qual && op_reg == op_read && !oe_n_sync_reg |=> data_oe && parity_oe && drive_active_reg)
    else $error("read data not driven after qualified edge");

  deselect_float_a: assert property (
    qual && op_reg == op_idle |=> !data_oe && !drive_active_reg)
    else $error("drivers active after deselect");

  write_float_a: assert property (
    qual && op_reg == op_write |=> !data_oe ##0 wr_pend_reg)
    else $error("drivers active in write data cycle");

  burst_step_a: assert property (
    qual && advance_or_load |=> burst_count_reg == BURST_W'($past(burst_count_reg) + BEAT_STEP))
    else $error("burst counter did not step");

  burst_order_a: assert property (
    qual && advance_or_load && burst_dir_reg != op_idle |=> addr_reg[BURST_W-1:0] ==
      ($past(order_reg) ? (base_reg[BURST_W-1:0] ^ burst_count_reg)
                        : BURST_W'(base_reg[BURST_W-1:0] + burst_count_reg)))
    else $error("burst address out of order");

  dir_kept_a: assert property (
    qual && advance_or_load |=> burst_dir_reg == $past(burst_dir_reg) && op_reg == $past(burst_dir_reg))
    else $error("burst direction changed mid burst");

  write_capture_a: assert property (
    qual && wr_pend_reg |=> wb.out_valid && !wr_pend_reg || $past(op_reg) == op_write)
    else $error("write beat not captured");

  sleep_enter_a: assert property (
    sleep_request [*2] |=> sleep_active_reg ##1 (op_reg == op_idle && !data_oe && !wr_pend_reg))
    else $error("sleep not entered in two clocks");

  sleep_exit_a: assert property (
    !sleep_request [*2] |=> !sleep_active_reg)
    else $error("sleep not left in two clocks");
endmodule // pipelined_burst_sram

/* logic/sram_pkg.sv */
/*
  constants, operation tags and the summary of behaviour for the pipelined burst sram.
  assumes one 40 MHz clock; every other file but the interface imports this package whole.
*/
// Overview of operation
// - clock qualifier high: edge ignored, pipeline and burst state held; buffered writes still drain
// - inputs captured on rising edge; read data launched from output registers
// - all selects active, write strobe high, load: read starts, address latched
// - read data driven after next qualified edge when output enable low
// - new operation may follow a read start with no wait state
// - deselect is pipelined; outputs float after the following qualified edge
// - two-bit burst counter gives four beats per loaded address, then wraps
// - strap low selects linear order, strap high interleaved order
// - advance high steps the burst, ignoring selects and write strobe
// - direction latched at burst start and kept for the whole burst
// - all selects active, write strobe low, load: write starts, lanes latched
// - edge after write start floats outputs and accepts next address
// - write data captured on second qualified edge after start
// - only selected byte lanes are written; others keep contents
// - sleep input preserves data; entry and exit take two clocks
// - accesses in flight when sleep starts are invalid
// - interleaved is start xor beat, linear is start plus beat modulo four
// - floating strap reads high, so interleaved order is the default
// - after power-up the device is deselected with drivers floating
package sram_pkg;
  localparam int ADDR_W_DEF = 19;  // word address width
  localparam int LANES_DEF  = 4;   // byte lanes, each with one parity bit
  localparam int LANE_W     = 8;   // data bits per lane
  localparam int BURST_W    = 2;   // low address bits walked by the burst counter
  localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP  = 2'h1;
  localparam logic STRAP_RESET = 1'h1;  // floating strap reads as interleaved
  localparam logic SYNC_RESET  = 1'h0;
  localparam logic OE_N_RESET  = 1'h1;  // output enable taken as inactive at reset

  // operation tag carried down the pipeline
  typedef enum logic [1:0] {op_idle, op_read, op_write} op_t;
endpackage

/* logic/wbuf_if.sv */
/*
  hand-off between the access pipeline and the two-entry write buffer.
  assumes both ends run on the same clock; tail view is for read forwarding only.
*/
interface wbuf_if #(parameter int WORD_W = 8);
  logic              in_valid;
  logic              in_ready;
  logic [WORD_W-1:0] in_word;
  logic              out_valid;
  logic              out_ready;
  logic [WORD_W-1:0] out_word;
  logic              tail_valid;
  logic [WORD_W-1:0] tail_word;

  modport filler (output in_valid, in_word, out_ready,
                  input  in_ready, out_valid, out_word, tail_valid, tail_word);
  modport store  (input  in_valid, in_word, out_ready,
                  output in_ready, out_valid, out_word, tail_valid, tail_word);
endinterface // wbuf_if

/* logic/write_buffer.sv */
/*
  two-entry buffer holding captured write beats until the array port is free.
  assumes the drain side may stall for any number of cycles; ready is registered.
*/
module write_buffer
  import sram_pkg::*;
#(
  parameter int WORD_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  wbuf_if.store    port_b
);
  logic [WORD_W-1:0] head_reg;
  logic [WORD_W-1:0] tail_reg;
  logic              head_valid_reg;
  logic              tail_valid_reg;
  logic              ready_reg;

  // handshake decode and next slot contents
  wire               push            = port_b.in_valid & ready_reg;
  wire               pop             = head_valid_reg & port_b.out_ready;
  wire               head_kept       = pop ? tail_valid_reg : head_valid_reg;
  wire               head_valid_next = head_kept | push;
  wire               tail_valid_next = (tail_valid_reg & ~pop) | (push & head_kept);
  wire [WORD_W-1:0]  head_next       = (push & ~head_kept) ? port_b.in_word : (pop ? tail_reg : head_reg);
  wire [WORD_W-1:0]  tail_next       = (push & head_kept) ? port_b.in_word : tail_reg;

  assign port_b.in_ready   = ready_reg;  // registered so the pin copy is a flop
  assign port_b.out_valid  = head_valid_reg;
  assign port_b.out_word   = head_reg;
  assign port_b.tail_valid = tail_valid_reg;
  assign port_b.tail_word  = tail_reg;

  // ready drops as soon as the tail fills, even if a pop would free it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      head_reg       <= '0;
      tail_reg       <= '0;
      head_valid_reg <= 1'h0;
      tail_valid_reg <= 1'h0;
      ready_reg      <= 1'h1;
    end else begin
      head_reg       <= head_next;
      tail_reg       <= tail_next;
      head_valid_reg <= head_valid_next;
      tail_valid_reg <= tail_valid_next;
      ready_reg      <= ~tail_valid_next;
    end
  end
endmodule // write_buffer

/* verification/sram_ctrl_model.sv */
/*
  controller model for the sram pin bus: commands, write data two taken edges on, stalls.
  assumes one bench process calls issue, and never while the device sleeps.
*/
module sram_ctrl_model
  import sram_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input  wire logic              clk,
  input  wire logic              accept_ready,
  input  wire logic              data_oe,
  input  wire logic [35:0]       rd_word,
  output var  logic [35:0]       wr_word,
  output var  logic              clock_qualifier_n,
  output var  logic [2:0]        sel,
  output var  logic              write_strobe_n,
  output var  logic              advance_or_load,
  output var  logic [3:0]        byte_lane_select_n,
  output var  logic [ADDR_W-1:0] address
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [35:0] drv, wd0, wd1;
  logic [35:0] last_w = '0;
  logic        drv_en, wv0, wv1, dir_w;
  logic [1:0]  rot;

  // shared lines: device first, then our drive, else the inverse of the last level
  assign wr_word = data_oe ? rd_word : drv_en ? drv : ~last_w;
  // last level kept so a released line never shows a stale word
  always @(posedge clk) last_w <= wr_word;

  // idle pins at time zero: deselected, no drive
  initial begin
    {drv_en, wv0, wv1, dir_w, rot} = '0;
    {drv, wd0, wd1} = '0;
    clock_qualifier_n = 1'b0;
    sel = 3'b111;
    write_strobe_n = 1'b1;
    advance_or_load = 1'b0;
    byte_lane_select_n = 4'hf;
    address = '0;
  end

  // pins change at the falling edge and hold until an edge is taken
  task automatic issue(input logic [1:0] kind, input logic [ADDR_W-1:0] a, input logic [3:0] ln,
                       input logic [35:0] w, input logic stall);
    logic rdy;
    @(negedge clk);
    rot = (rot == 2'd2) ? 2'd0 : rot + 2'd1;
    sel = (kind == 2'd0) ? (3'b010 ^ (3'b001 << rot)) : (kind == 2'd3) ? 3'($urandom) : 3'b010;
    write_strobe_n = (kind == 2'd3) ? 1'($urandom) : (kind != 2'd2);
    advance_or_load = (kind == 2'd3);
    byte_lane_select_n = ln;
    address = (kind == 2'd3) ? ADDR_W'($urandom) : a;
    drv_en = wv1;
    drv = wd1;
    clock_qualifier_n = stall;
    forever begin
      rdy = accept_ready;
      @(posedge clk);
      if (!clock_qualifier_n && rdy) break;
      @(negedge clk);
      clock_qualifier_n = 1'b0;
    end
    #1;
    drv_en = 1'b0;  // hold over, let go of the lines
    if (kind == 2'd1 || kind == 2'd2) dir_w = (kind == 2'd2);
    wv1 = wv0;
    wd1 = wd0;
    wv0 = (kind == 2'd2) || (kind == 2'd3 && dir_w);
    wd0 = w;
  endtask
endmodule // sram_ctrl_model

/* verification/testbench.sv */
/*
  self-checking bench for the pipelined burst sram: seeded random and directed traffic.
  assumes the controller model beside it and a 6-bit word address for a short run.
*/
module testbench
  import sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 6;
  logic          clk, sys_rst, output_enable_n, sleep_request, burst_order, clock_qualifier_n;
  logic          write_strobe_n, advance_or_load, accept_ready, data_oe, parity_oe;
  logic          prev_rd, oe_on, b_dir;
  logic [1:0]    k, b_beat;
  logic [2:0]    sel;
  logic [3:0]    byte_lane_select_n, parity_out;
  logic [AW-1:0] address, a, b_start;
  logic [AW:0]   wq1, wq2;
  logic [31:0]   data_out;
  logic [35:0]   wr_word, prev_exp;
  logic [35:0]   ref_mem [64];
  int            mismatches, total_checks;

  pipelined_burst_sram #(.ADDR_W(AW), .LANES(LANES_DEF)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .clock_qualifier_n(clock_qualifier_n), .chip_select_first_n(sel[0]),
    .chip_select_second(sel[1]), .chip_select_third_n(sel[2]), .write_strobe_n(write_strobe_n),
    .advance_or_load(advance_or_load), .byte_lane_select_n(byte_lane_select_n), .address(address),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .burst_order(burst_order),
    .data_in(wr_word[31:0]), .data_out(data_out), .data_oe(data_oe), .parity_in(wr_word[35:32]),
    .parity_out(parity_out), .parity_oe(parity_oe), .accept_ready(accept_ready));

  sram_ctrl_model #(.ADDR_W(AW)) ctrl_u (
    .clk(clk), .accept_ready(accept_ready), .data_oe(data_oe), .rd_word({parity_out, data_out}),
    .wr_word(wr_word), .clock_qualifier_n(clock_qualifier_n), .sel(sel), .write_strobe_n(write_strobe_n),
    .advance_or_load(advance_or_load), .byte_lane_select_n(byte_lane_select_n), .address(address));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // burst position of beat n from a two-bit start
  function automatic logic [1:0] beat_addr(logic [1:0] s, logic [1:0] n, logic ord);
    return ord ? (s ^ n) : (s + n);
  endfunction

  // new bytes and parity where a lane select is low, old contents elsewhere
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] w, logic [3:0] ln);
    logic [35:0] m;
    m = '0;
    for (int l = 0; l < 4; l++) begin
      m[8*l +: 8] = {8{!ln[l]}};
      m[32+l] = !ln[l];
    end
    return (o & ~m) | (w & m);
  endfunction

  // compare a flag
  task automatic cmp_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // compare a read word with its parity
  task automatic cmp_word(logic [35:0] got, logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one command, then check the beat loaded one taken edge earlier
  task automatic op(logic [1:0] kind, logic [AW-1:0] ad, logic [3:0] ln, logic st);
    logic [35:0]   w;
    logic [AW-1:0] cur;
    logic          rd, wr;
    w = 36'({$urandom(), $urandom()});
    cur = ad;
    if (kind == 2'd1 || kind == 2'd2) begin
      b_start = ad;
      b_beat = 2'd0;
      b_dir = (kind == 2'd2);
    end else if (kind == 2'd3) begin
      b_beat = b_beat + 2'd1;
      cur = {b_start[AW-1:2], beat_addr(b_start[1:0], b_beat, burst_order)};
    end
    rd = (kind == 2'd1 || (kind == 2'd3 && !b_dir)) && oe_on;
    wr = kind == 2'd2 || (kind == 2'd3 && b_dir);
    if (wr) ref_mem[cur] = merge(ref_mem[cur], w, ln);
    ctrl_u.issue(kind, ad, ln, w, st);
    cmp_bit(data_oe, prev_rd);
    cmp_bit(parity_oe, prev_rd);
    if (prev_rd) cmp_word({parity_out, data_out}, prev_exp);
    prev_rd = rd;
    prev_exp = ref_mem[cur];
    wq2 = wq1;
    wq1 = {!wr, cur};
  endtask

  // cut a hang short; the run needs far less than this span
  initial begin
    #(25 * 20000);
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    void'($urandom(32'h6b84));
    {sys_rst, output_enable_n, sleep_request, burst_order} = 4'b1001;
    {mismatches, total_checks} = '0;
    {prev_rd, oe_on, prev_exp, b_dir, b_beat, b_start} = '0;
    {wq1, wq2} = '1;
    repeat (6) @(negedge clk);
    cmp_bit(data_oe, 1'b0);
    cmp_bit(accept_ready, 1'b1);
    sys_rst = 1'b0;
    repeat (3) op(2'd0, '0, 4'hf, 1'b0);
    oe_on = 1'b1;
    // fill every word back to back with all lanes
    for (int i = 0; i < 64; i++) op(2'd2, AW'(i), 4'h0, 1'b0);
    // random loads and deselects with stalls; no read right behind a write of its word
    for (int i = 0; i < 300; i++) begin
      k = 2'($urandom_range(2));
      a = AW'($urandom);
      if (k == 2'd1 && ({1'b0, a} == wq1 || {1'b0, a} == wq2)) k = 2'd0;
      op(k, a, 4'($urandom), ($urandom_range(3) == 0));
    end
    // bursts in both orders from each start; the read runs one beat past the wrap
    for (int o = 0; o < 2; o++) begin
      // drain the pipe first, so the spare edge after the strap change is a plain deselect
      repeat (2) op(2'd0, '0, 4'hf, 1'b0);
      @(negedge clk);
      burst_order = o[0];
      repeat (3) op(2'd0, '0, 4'hf, 1'b0);
      for (int s = 0; s < 4; s++) begin
        a = AW'(4 * (4 + s) + s);
        op(2'd2, a, 4'($urandom), 1'b0);
        repeat (3) op(2'd3, '0, 4'($urandom), 1'($urandom));
        repeat (2) op(2'd0, '0, 4'hf, 1'b0);
        op(2'd1, a, 4'hf, 1'b0);
        repeat (4) op(2'd3, '0, 4'($urandom), 1'($urandom));
        repeat (2) op(2'd0, '0, 4'hf, 1'b0);
      end
    end
    // output enable high: reads float, writes still land
    @(negedge clk);
    output_enable_n = 1'b1;
    repeat (3) op(2'd0, '0, 4'hf, 1'b0);
    oe_on = 1'b0;
    op(2'd1, 6'h05, 4'hf, 1'b0);
    op(2'd2, 6'h09, 4'h5, 1'b0);
    repeat (2) op(2'd0, '0, 4'hf, 1'b0);
    @(negedge clk);
    output_enable_n = 1'b0;
    repeat (3) op(2'd0, '0, 4'hf, 1'b0);
    oe_on = 1'b1;
    // sleep with the pipeline drained: outputs float, stored words survive
    @(negedge clk);
    sleep_request = 1'b1;
    repeat (6) begin
      @(negedge clk);
      cmp_bit(data_oe, 1'b0);
    end
    sleep_request = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 4; i++) op(2'd1, AW'(i * 9), 4'hf, 1'b0);
    repeat (2) op(2'd0, '0, 4'hf, 1'b0);
    conclude();
  end
endmodule // testbench
